// ---- rtl/sap_pkg.sv ----
// Purpose: constants, types and decoders of the serial audio port
// Assumes: 125 MHz system clock, registers eight bits wide
// Notes:   link clock is the bit clock pin; config is quasi-static
package sap_pkg;

    // register map
    localparam logic [15:0] SAP_ADDR_SPC0   = 16'h4015;
    localparam logic [15:0] SAP_ADDR_SPC1   = 16'h4016;
    localparam logic [15:0] SAP_ADDR_CC0    = 16'h4017;
    localparam logic [15:0] SAP_ADDR_CC1    = 16'h4018;
    localparam logic [15:0] SAP_ADDR_STAT   = 16'h4019;

    // reset: slave, stereo, I2S framing
    localparam logic [7:0]  SAP_RST_SPC0    = 8'h00;
    localparam logic [7:0]  SAP_RST_SPC1    = 8'h00;
    localparam logic [7:0]  SAP_RST_CC0     = 8'h00;
    localparam logic [7:0]  SAP_RST_CC1     = 8'h00;

    // serial_port_control_first fields
    localparam int          SAP_B_MASTER    = 0;
    localparam int          SAP_B_SLOTS     = 1;
    localparam int          SAP_B_LR_INV    = 3;
    localparam int          SAP_B_BCLK_INV  = 4;
    localparam int          SAP_B_PULSE     = 5;
    localparam int          SAP_B_RISE      = 6;
    // serial_port_control_second fields
    localparam int          SAP_B_DLY       = 0;
    localparam int          SAP_B_DLY16     = 2;
    localparam int          SAP_B_BPF       = 5;
    // converter_control_first fields
    localparam int          SAP_B_FS96      = 0;
    // status fields
    localparam int          SAP_B_ST_MASTER = 0;
    localparam int          SAP_B_ST_REFUSE = 1;
    localparam int          SAP_B_ST_LOCK   = 2;

    localparam logic [1:0]  SAP_SLOTS_2     = 2'h0;
    localparam logic [1:0]  SAP_SLOTS_4     = 2'h1;
    localparam logic [1:0]  SAP_SLOTS_8     = 2'h2;

    localparam logic [2:0]  SAP_BPF_64      = 3'h0;
    localparam logic [2:0]  SAP_BPF_32      = 3'h1;
    localparam logic [2:0]  SAP_BPF_128     = 3'h2;
    localparam logic [2:0]  SAP_BPF_256     = 3'h3;

    localparam logic [1:0]  SAP_DLY_1       = 2'h0;
    localparam logic [1:0]  SAP_DLY_0       = 2'h1;
    localparam logic [1:0]  SAP_DLY_8       = 2'h2;
    localparam logic [1:0]  SAP_DLY_12      = 2'h3;
    localparam logic [4:0]  SAP_DV_0        = 5'h00;
    localparam logic [4:0]  SAP_DV_1        = 5'h01;
    localparam logic [4:0]  SAP_DV_8        = 5'h08;
    localparam logic [4:0]  SAP_DV_12       = 5'h0c;
    localparam logic [4:0]  SAP_DV_16       = 5'h10;

    localparam logic [4:0]  SAP_WORD_LEN    = 5'h18;

    // bclk divider for a 32 bclk frame, shifted per frame length
    localparam int          SAP_CLK_HZ      = 125_000_000;
    localparam int          SAP_FS_48K      = 48_000;
    localparam int          SAP_FS_96K      = 96_000;
    localparam int          SAP_REF_BITS    = 32;
    localparam logic [3:0]  SAP_REF_LOG     = 4'h5;
    localparam logic [7:0]  SAP_DIV_48K     = 8'(SAP_CLK_HZ / (2 * SAP_FS_48K * SAP_REF_BITS));
    localparam logic [7:0]  SAP_DIV_96K     = 8'(SAP_CLK_HZ / (2 * SAP_FS_96K * SAP_REF_BITS));

    typedef struct packed {
        logic       master;
        logic [1:0] slots;
        logic       lr_inv;
        logic       bclk_inv;
        logic       pulse;
        logic       start_rise;
        logic [2:0] bpf;
        logic [1:0] dly;
        logic       dly16;
        logic       fs96;
    } sap_cfg_t;

    typedef struct packed {
        logic [2:0]  slot;
        logic [23:0] data;
    } sap_word_t;

    function automatic sap_cfg_t sap_decode(input logic [7:0] c0,
                                            input logic [7:0] c1,
                                            input logic [7:0] k0);
        sap_cfg_t c;
        c.master     = c0[SAP_B_MASTER];
        c.slots      = c0[SAP_B_SLOTS +: 2];
        c.lr_inv     = c0[SAP_B_LR_INV];
        c.bclk_inv   = c0[SAP_B_BCLK_INV];
        c.pulse      = c0[SAP_B_PULSE];
        c.start_rise = c0[SAP_B_RISE];
        c.bpf        = c1[SAP_B_BPF +: 3];
        c.dly        = c1[SAP_B_DLY +: 2];
        c.dly16      = c1[SAP_B_DLY16];
        c.fs96       = k0[SAP_B_FS96];
        return c;
    endfunction

    // log2 of bclk per frame; unknown codes mean 64
    function automatic logic [3:0] sap_bpf_log(input logic [2:0] code);
        case (code)
            SAP_BPF_32:  return 4'h5;
            SAP_BPF_128: return 4'h7;
            SAP_BPF_256: return 4'h8;
            default:     return 4'h6;
        endcase
    endfunction

    function automatic logic [3:0] sap_slot_log(input logic [1:0] code);
        case (code)
            SAP_SLOTS_4: return 4'h2;
            SAP_SLOTS_8: return 4'h3;
            default:     return 4'h1;
        endcase
    endfunction

    function automatic logic [4:0] sap_delay(input logic [1:0] code, input logic d16);
        if (d16) begin
            return SAP_DV_16;
        end
        case (code)
            SAP_DLY_0:  return SAP_DV_0;
            SAP_DLY_8:  return SAP_DV_8;
            SAP_DLY_12: return SAP_DV_12;
            default:    return SAP_DV_1;
        endcase
    endfunction

endpackage

// ---- rtl/sap_sync2.sv ----
// Purpose: two-flop synchroniser
// Assumes: levels or toggles held several destination clocks
// Notes:   no reset; flushes in two clocks
`timescale 1ns/1ns
module sap_sync2 #(
    parameter int W = 1
) (
    input  wire logic         clk,   // destination clock
    input  wire logic [W-1:0] d,     // source-domain levels
    output logic      [W-1:0] q      // synchronised levels
);
    import sap_pkg::*;

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sap_sync_t;

    sap_sync_t s_r;
    sap_sync_t s_nxt;

    always_comb begin
        s_nxt.s1 = d;
        s_nxt.s2 = s_r.s1;
    end

    always_ff @(posedge clk) begin
        s_r <= s_nxt;
    end

    assign q = s_r.s2;
endmodule

// ---- rtl/sap_serial_port.sv ----
// Purpose: serial audio port, stereo and TDM4/TDM8 framing
// Assumes: bit and frame clocks synchronous to the master clock
// Notes:   link logic runs on bclk; config changes only while idle
// Contract
// R1: stereo, four-slot or eight-slot frames both ways
// R2: words are two's complement, MSB first
// R3: left word precedes right word in stereo
// R4: TDM4 slots 0-1 first half, 2-3 second
// R5: TDM8 slots 0-3 first half, 4-7 second
// R6: slave clocks come synchronous to master clock
// R7: one clock pair, shared master/slave role
// R8: I2S, left, right-justified and TDM formats offered
// R9: input takes up to 24 bits, rest dropped
// R10: any bit clock count per frame works; code needs the count set in the bpf field (32-256)
// R11: frame, bit clock polarity and format selectable
// R12: TDM frame clock square or one-bit pulse
// R13: TDM output always driven
// R14: no TDM8 master at 96 kHz
// R15: right-justified needs frame length and delay fields
// R16: I2S falls, square, 64 bclk, 1 delay
// R17: left-justified rises, 64 bclk, no delay
// R18: right-justified rises, 64 bclk, 8/12/16 delay
// R19: TDM 64-256 bclk, 1 delay, edge by mode
// R20: data changes falling, sampled rising bclk
// R21: master divides master clock into bit, frame clocks
`timescale 1ns/1ns
module sap_serial_port (
    input  wire logic              clk,        // system clock
    input  wire logic              reset,      // synchronous, active high
    input  wire logic [15:0]       reg_addr,   // register address
    input  wire logic [7:0]        reg_wdata,  // register write data
    input  wire logic              reg_wr,     // write strobe
    input  wire logic              reg_rd,     // read strobe
    output logic      [7:0]        reg_rdata,  // read data, one cycle late
    input  wire logic              bclk_i,     // bit clock pin, link clock
    output logic                   bclk_o,     // bit clock drive
    output logic                   bclk_oe,    // bit clock drive enable
    input  wire logic              lrclk_i,    // frame clock pin level
    output logic                   lrclk_o,    // frame clock drive
    output logic                   lrclk_oe,   // frame clock drive enable
    input  wire logic              sdata_in,   // serial data input
    output logic                   sdata_out,  // serial data output
    output logic                   rx_valid,   // received word pulse
    output sap_pkg::sap_word_t     rx_word,    // received slot and data
    input  wire logic              tx_we,      // transmit word write
    input  wire sap_pkg::sap_word_t tx_word    // transmit slot and data
);
    import sap_pkg::*;

    typedef struct packed {
        logic [7:0]       spc0;
        logic [7:0]       spc1;
        logic [7:0]       cc0;
        logic [7:0]       cc1;
        logic [7:0]       rdata;
        sap_cfg_t         cfg;
        logic             refused;
        logic [7:0]       div;
        logic             bclk;
        logic [7:0][23:0] tx_mem;
        logic [23:0]      tx_xfer;
        logic             ack_tgl;
        logic             req_seen;
        logic             rx_seen;
        logic             locked;
        logic             rx_valid;
        sap_word_t        rx_word;
    } sap_sys_t;

    typedef struct packed {
        logic [8:0]  pos;
        logic        lr_prev;
        logic [23:0] rx_sr;
        logic [4:0]  rx_n;
        sap_word_t   rx_hold;
        logic        rx_tgl;
        logic [23:0] tx_sr;
        logic [4:0]  tx_k;
        logic [23:0] tx_cur;
        logic [23:0] tx_next;
        logic [2:0]  req_slot;
        logic        req_tgl;
        logic        ack_seen;
        logic        seen;
        logic        tx_bit;
        logic        lr_out;
    } sap_link_t;

    typedef struct packed {
        logic sdata;
        logic lrclk;
    } sap_pin_t;

    sap_sys_t  s_r;
    sap_sys_t  s_nxt;
    sap_link_t l_r;
    sap_link_t l_nxt;
    sap_pin_t  p_r;
    sap_pin_t  p_nxt;

    logic      link_clk;
    sap_cfg_t  cfg_l;
    logic      ack_l;
    logic      rst_l;
    logic      rxt_s;
    logic      reqt_s;
    logic      seen_s;

    // polarity muxes the clock itself: change it only while idle
    assign link_clk = bclk_i ^ s_r.cfg.bclk_inv;  // [R11] [R20]

    // to link: config, ack toggle, reset
    sap_sync2 #(.W($bits(sap_cfg_t) + 2)) u_to_link (
        .clk (link_clk),
        .d   ({reset, s_r.ack_tgl, s_r.cfg}),
        .q   ({rst_l, ack_l, cfg_l})
    );

    // to clk: word and request toggles, frame-seen level
    sap_sync2 #(.W(3)) u_to_sys (
        .clk (clk),
        .d   ({l_r.rx_tgl, l_r.req_tgl, l_r.seen}),
        .q   ({rxt_s, reqt_s, seen_s})
    );

    // clk side: registers, master bclk, handshakes
    always_comb begin
        sap_cfg_t   cfg;
        logic [3:0] blog;
        logic [7:0] half;
        s_nxt = s_r;
        cfg   = sap_decode(s_r.spc0, s_r.spc1, s_r.cc0);  // [R8] [R11] [R15]
        blog  = sap_bpf_log(s_r.cfg.bpf);
        half  = 8'h00;

        // TDM8 at 96 kHz stays slave
        cfg.master = cfg.master && !(cfg.slots == SAP_SLOTS_8 && cfg.fs96);  // [R7] [R14]
        s_nxt.cfg     = cfg;
        s_nxt.refused = s_r.spc0[SAP_B_MASTER] && !cfg.master;  // [R14]

        if (reg_wr) begin
            unique case (reg_addr)
                SAP_ADDR_SPC0: s_nxt.spc0 = reg_wdata;
                SAP_ADDR_SPC1: s_nxt.spc1 = reg_wdata;
                SAP_ADDR_CC0:  s_nxt.cc0  = reg_wdata;
                SAP_ADDR_CC1:  s_nxt.cc1  = reg_wdata;
                default:       ;
            endcase
        end

        s_nxt.rdata = 8'h00;
        if (reg_rd) begin
            unique case (reg_addr)
                SAP_ADDR_SPC0: s_nxt.rdata = s_r.spc0;
                SAP_ADDR_SPC1: s_nxt.rdata = s_r.spc1;
                SAP_ADDR_CC0:  s_nxt.rdata = s_r.cc0;
                SAP_ADDR_CC1:  s_nxt.rdata = s_r.cc1;
                SAP_ADDR_STAT: begin
                    s_nxt.rdata[SAP_B_ST_MASTER] = s_r.cfg.master;
                    s_nxt.rdata[SAP_B_ST_REFUSE] = s_r.refused;
                    s_nxt.rdata[SAP_B_ST_LOCK]   = s_r.locked;
                end
                default:       ;
            endcase
        end

        // bclk period = 2 * half clk cycles
        half = (s_r.cfg.fs96 ? SAP_DIV_96K : SAP_DIV_48K) >> (blog - SAP_REF_LOG);  // [R21]
        if (half == 8'h00) begin
            half = 8'h01;
        end
        if (!s_r.cfg.master) begin
            s_nxt.div  = 8'h00;
            s_nxt.bclk = 1'b0;
        end else if (s_r.div == 8'h00) begin
            s_nxt.div  = half - 8'h01;  // [R21]
            s_nxt.bclk = ~s_r.bclk;
        end else begin
            s_nxt.div  = s_r.div - 8'h01;
        end

        if (tx_we) begin
            s_nxt.tx_mem[tx_word.slot] = tx_word.data;
        end

        // req_slot is stable behind the toggle
        if (reqt_s != s_r.req_seen) begin
            s_nxt.req_seen = reqt_s;
            s_nxt.tx_xfer  = s_r.tx_mem[l_r.req_slot];
            s_nxt.ack_tgl  = ~s_r.ack_tgl;
        end

        s_nxt.rx_valid = 1'b0;
        if (rxt_s != s_r.rx_seen) begin
            s_nxt.rx_seen  = rxt_s;
            s_nxt.rx_valid = 1'b1;
            s_nxt.rx_word  = l_r.rx_hold;
        end
        s_nxt.locked = seen_s;

        if (reset) begin
            s_nxt          = '0;
            s_nxt.spc0     = SAP_RST_SPC0;
            s_nxt.spc1     = SAP_RST_SPC1;
            s_nxt.cc0      = SAP_RST_CC0;
            s_nxt.cc1      = SAP_RST_CC1;
            s_nxt.cfg      = sap_decode(SAP_RST_SPC0, SAP_RST_SPC1, SAP_RST_CC0);
            s_nxt.req_seen = reqt_s;
            s_nxt.rx_seen  = rxt_s;
        end
    end

    always_ff @(posedge clk) begin
        s_r <= s_nxt;
    end

    // link side: samples on the rising effective bclk
    always_comb begin
        logic [3:0]  blog;
        logic [3:0]  slog;
        logic [8:0]  bpf;
        logic [8:0]  mid;
        logic [8:0]  smask;
        logic [2:0]  nsl_mask;
        logic [4:0]  dly;
        logic        fl;
        logic        lr;
        logic        st_edge;
        logic        md_edge;
        logic [8:0]  pos;
        logic [8:0]  q;
        logic [8:0]  bis;
        logic [8:0]  tbis;
        logic [2:0]  slot;
        logic [2:0]  tslot;
        logic [23:0] sr;
        logic [4:0]  nn;
        logic [23:0] word;
        logic        bit_o;
        l_nxt    = l_r;
        pos      = 9'h000;
        blog     = sap_bpf_log(cfg_l.bpf);
        slog     = blog - sap_slot_log(cfg_l.slots);
        bpf      = 9'h001 << blog;
        mid      = bpf >> 1;
        smask    = 9'((9'h001 << slog) - 9'h001);
        nsl_mask = 3'((4'h1 << sap_slot_log(cfg_l.slots)) - 4'h1);
        dly      = sap_delay(cfg_l.dly, cfg_l.dly16);  // [R16] [R17] [R18] [R19]
        fl       = cfg_l.start_rise;  // [R16] [R17] [R19]
        lr       = lrclk_i ^ cfg_l.lr_inv;  // [R11]

        // slave resyncs on each frame edge: frame length must match the bpf field
        st_edge = !cfg_l.master && (lr == fl) && (l_r.lr_prev != fl);  // [R6] [R10]
        md_edge = !cfg_l.master && !cfg_l.pulse && (lr != fl) && (l_r.lr_prev == fl);  // [R12]
        l_nxt.lr_prev = lr;

        q = l_r.pos + 9'h001;
        if (q >= bpf) begin
            q = 9'h000;
        end
        if (st_edge) begin
            pos = 9'h000;
        end else if (md_edge) begin
            pos = mid;  // [R3] [R4] [R5]
        end else begin
            pos = q;  // [R10]
        end
        l_nxt.pos  = pos;
        l_nxt.seen = l_r.seen | st_edge | cfg_l.master;

        // low slots in the first half, high in the second
        slot = 3'(pos >> slog);  // [R1] [R3] [R4] [R5]
        bis  = pos & smask;
        sr   = l_r.rx_sr;
        nn   = l_r.rx_n;
        if (bis == {4'h0, dly}) begin
            sr = {23'h00_0000, sdata_in};
            nn = 5'h01;
        end else if (bis > {4'h0, dly} && l_r.rx_n < SAP_WORD_LEN) begin
            sr = {l_r.rx_sr[22:0], sdata_in};  // [R2]
            nn = l_r.rx_n + 5'h01;
        end
        // bits past 24 are not shifted in
        l_nxt.rx_sr = sr;  // [R9]
        l_nxt.rx_n  = nn;
        if (bis == smask) begin
            l_nxt.rx_hold.slot = slot;
            l_nxt.rx_hold.data = sr << (SAP_WORD_LEN - nn);  // [R2] [R9]
            l_nxt.rx_tgl       = ~l_r.rx_tgl;
            l_nxt.rx_n         = 5'h00;
        end

        if (ack_l != l_r.ack_seen) begin
            l_nxt.ack_seen = ack_l;
            l_nxt.tx_next  = s_r.tx_xfer;
        end

        // tx bit for the next period, launched on the change edge
        q     = pos + 9'h001;
        if (q >= bpf) begin
            q = 9'h000;
        end
        tslot = 3'(q >> slog);
        tbis  = q & smask;
        word  = l_r.tx_cur;
        if (tbis == 9'h000) begin
            // fetch a slot ahead so the word is home before its delay
            l_nxt.tx_cur   = l_r.tx_next;
            word           = l_r.tx_next;
            l_nxt.req_slot = (tslot + 3'h1) & nsl_mask;
            l_nxt.req_tgl  = ~l_r.req_tgl;
        end
        // idle bits driven low, never released
        bit_o = 1'b0;  // [R13]
        if (tbis == {4'h0, dly}) begin
            bit_o       = word[23];  // [R2]
            l_nxt.tx_sr = word << 1;
            l_nxt.tx_k  = 5'h01;
        end else if (tbis > {4'h0, dly} && l_r.tx_k < SAP_WORD_LEN) begin
            bit_o       = l_r.tx_sr[23];  // [R18]
            l_nxt.tx_sr = l_r.tx_sr << 1;
            l_nxt.tx_k  = l_r.tx_k + 5'h01;
        end
        l_nxt.tx_bit = bit_o;

        // master frame clock: square or one-bit pulse
        if (cfg_l.pulse) begin
            l_nxt.lr_out = ((q == 9'h000) ? fl : ~fl) ^ cfg_l.lr_inv;  // [R12] [R21]
        end else begin
            l_nxt.lr_out = ((q < mid) ? fl : ~fl) ^ cfg_l.lr_inv;  // [R16] [R21]
        end

        if (rst_l) begin
            l_nxt          = '0;
            l_nxt.ack_seen = ack_l;
        end
    end

    always_ff @(posedge link_clk) begin
        l_r <= l_nxt;
    end

    // data and frame clock change on the falling effective edge
    always_comb begin
        p_nxt.sdata = l_r.tx_bit;  // [R20]
        p_nxt.lrclk = l_r.lr_out;
        if (rst_l) begin
            p_nxt = '0;
        end
    end

    always_ff @(negedge link_clk) begin
        p_r <= p_nxt;
    end

    assign reg_rdata = s_r.rdata;
    assign bclk_o    = s_r.bclk;
    assign bclk_oe   = s_r.cfg.master;  // [R7]
    assign lrclk_o   = p_r.lrclk;
    assign lrclk_oe  = s_r.cfg.master;  // [R7]
    assign sdata_out = p_r.sdata;  // [R13]
    assign rx_valid  = s_r.rx_valid;
    assign rx_word   = s_r.rx_word;
endmodule

// ---- dv/sap_serial_port_chk.sv ----
// Purpose: port assertions of the serial audio port
// Assumes: config changes only while idle
// Notes:   bound into every port instance
`timescale 1ns/1ns
module sap_serial_port_chk import sap_pkg::*; (
    input wire logic        clk,       // system clock
    input wire logic        reset,     // sync reset
    input wire logic [15:0] reg_addr,  // address
    input wire logic [7:0]  reg_wdata, // write data
    input wire logic        reg_wr,    // write strobe
    input wire logic        reg_rd,    // read strobe
    input wire logic [7:0]  reg_rdata, // read data
    input wire logic        bclk_o,    // bit clock drive
    input wire logic        bclk_oe,   // bit clock enable
    input wire logic        lrclk_oe,  // frame clock enable
    input wire logic        rx_valid,  // word pulse
    input wire sap_word_t   rx_word    // received word
);
    logic [7:0] s0_r, s1_r, k0_r, k1_r, q_r, h_r, nm_r, exp_rd, half;
    logic       allow;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    assign allow = s0_r[SAP_B_MASTER] && !(s0_r[2:1] == SAP_SLOTS_8 && k0_r[SAP_B_FS96]);
    assign exp_rd = reg_addr == SAP_ADDR_SPC0 ? s0_r : reg_addr == SAP_ADDR_SPC1 ? s1_r :
                    reg_addr == SAP_ADDR_CC0 ? k0_r : reg_addr == SAP_ADDR_CC1 ? k1_r : 8'h00;
    assign half = (k0_r[SAP_B_FS96] ? 8'h14 : 8'h28) >> (s1_r[7:5] == SAP_BPF_32 ? 2'h0 :
                  s1_r[7:5] == SAP_BPF_128 ? 2'h2 : s1_r[7:5] == SAP_BPF_256 ? 2'h3 : 2'h1);
    // q_r saturates: skip bclk checks while settling after a write
    always_ff @(posedge clk) begin
        if (reset) begin
            {s0_r, s1_r, k0_r, k1_r, q_r, h_r, nm_r} <= '0;
        end else begin
            if (reg_wr && reg_addr == SAP_ADDR_SPC0) s0_r <= reg_wdata;
            if (reg_wr && reg_addr == SAP_ADDR_SPC1) s1_r <= reg_wdata;
            if (reg_wr && reg_addr == SAP_ADDR_CC0) k0_r <= reg_wdata;
            if (reg_wr && reg_addr == SAP_ADDR_CC1) k1_r <= reg_wdata;
            q_r <= reg_wr ? 8'h00 : q_r + 8'(q_r != 8'hff);
            h_r <= bclk_o ? h_r + 8'h01 : 8'h00;
            nm_r <= allow ? 8'h00 : nm_r + 8'(nm_r != 8'h0f);
        end
    end
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("stray read data");
    a_reg_readback: assert property (
        reg_rd && !reg_wr && reg_addr != SAP_ADDR_STAT |=> reg_rdata == $past(exp_rd))
        else $error("bad read value");
    a_role_shared: assert property (lrclk_oe == bclk_oe)
        else $error("clock roles differ");
    a_slave_quiet: assert property (!bclk_oe |-> !bclk_o)
        else $error("bclk driven as slave");
    a_master_refuse: assert property (nm_r == 8'h0f |-> !bclk_oe)
        else $error("master not refused");
    a_rx_hold: assert property (!rx_valid |-> $stable(rx_word))
        else $error("rx word changed");
    a_rx_pulse: assert property (rx_valid |=> !rx_valid)
        else $error("rx pulse too long");
    a_bclk_half: assert property (
        bclk_oe && q_r == 8'hff && $fell(bclk_o) |-> h_r == half)
        else $error("bclk high time wrong");
    c_tdm8_slot: cover property (rx_valid && rx_word.slot == 3'h7);
    c_master: cover property ($rose(bclk_oe));
    c_refused: cover property (nm_r == 8'h0f && s0_r[SAP_B_MASTER]);
endmodule
bind sap_serial_port sap_serial_port_chk i_chk (.*);

// ---- dv/sap_codec_model.sv ----
// Purpose: external converter, slave-mode clock source
// Assumes: bit clock 12 ns, unrelated to the system clock
// Notes:   bclk stands low while run is low
`timescale 1ns/1ns
module sap_codec_model (
    input  wire logic       run,       // bit clock enable
    input  wire logic       rise,      // frame starts rising
    input  wire logic       pulse,     // one-bit frame pulse
    input  wire logic [8:0] bpf,       // bit clocks per frame
    input  wire logic [5:0] sw,        // bit clocks per slot
    input  wire logic [4:0] dly,       // word delay
    input  wire logic       sdata_out, // data from device
    output logic            bclk,      // bit clock
    output logic            lrclk,     // frame clock
    output logic            sdata      // data to device
);
    logic [23:0] cap [8];
    logic [23:0] w;
    int          pos = -1, k = 0, d = 0;
    function automatic logic [23:0] pat(input int s);
        return 24'h9c_3a50 ^ (24'h11_1111 * 24'(s));
    endfunction
    initial begin
        bclk = 0;
        lrclk = 0;
        sdata = 0;
        forever begin
            #6;
            if (run || bclk) bclk = ~bclk;
        end
    end
    always @(posedge run) pos = -1;
    always @(negedge bclk) begin
        pos = (pos + 1) % int'(bpf);
        k = pos / int'(sw);
        d = pos % int'(sw) - int'(dly);
        w = pat(k);
        lrclk = pulse ? pos == 0 : (pos < int'(bpf) / 2) == rise;
        // toggle outside the word so stray sampling shows
        sdata = (d >= 0 && d < 24) ? w[23 - d] : ~sdata;
    end
    always @(posedge bclk) begin
        if (d >= 0 && d < 24) cap[k][23 - d] = sdata_out;
    end
endmodule

// ---- dv/sap_serial_port_tb.sv ----
// Purpose: self-checking bench for the serial audio port
// Assumes: model clocks slave modes; master clocks loop back
// Notes:   each scenario is one task
`timescale 1ns/1ns
module sap_serial_port_tb;
    import sap_pkg::*;
    logic        clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, tx_we = 0, run = 1;
    logic        rise = 0, pulse = 0, m_bclk, m_lr, m_sd;
    logic [15:0] reg_addr = '0;
    logic [7:0]  reg_wdata = '0, reg_rdata;
    logic        bclk_o, bclk_oe, lrclk_o, lrclk_oe, sdata_out, rx_valid;
    logic [8:0]  bpf = 9'h040;
    logic [5:0]  sw = 6'h20;
    logic [4:0]  dly = 5'h01;
    sap_word_t   tx_word = '0, rx_word, rx_got [8];
    int          n_errors = 0, cmp_count = 0, cyc = 0;
    wire         bclk_i = bclk_oe ? bclk_o : m_bclk;
    wire         lrclk_i = lrclk_oe ? lrclk_o : m_lr;
    sap_serial_port i_dut (.*, .sdata_in(m_sd));
    sap_codec_model i_model (.*, .bclk(m_bclk), .lrclk(m_lr), .sdata(m_sd));
    initial forever #4 clk = ~clk;
    always @(negedge clk) if (rx_valid === 1'b1) rx_got[rx_word.slot] = rx_word;
    task automatic stop_test;
        if (n_errors == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            n_errors++;
            stop_test();
        end
    end
    task automatic chk_b(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t byte %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_w(input logic [23:0] got, input logic [23:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t word %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1;
        @(negedge clk);
        reg_wr = 0;
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1;
        @(negedge clk);
        reg_rd = 0;
        d = reg_rdata;
    endtask
    task automatic t_regs;
        logic [7:0] d;
        run = 0;
        for (int i = 0; i < 4; i++) begin
            rd(SAP_ADDR_SPC0 + 16'(i), d);
            chk_b(d, 8'h00);
            wr(SAP_ADDR_SPC0 + 16'(i), 8'h5a + 8'(i));
            rd(SAP_ADDR_SPC0 + 16'(i), d);
            chk_b(d, 8'h5a + 8'(i));
        end
        wr(SAP_ADDR_STAT, 8'hff);
        rd(SAP_ADDR_STAT, d);
        chk_b(d & 8'h03, 8'h00);
        rd(16'h4014, d);
        chk_b(d, 8'h00);
        wr(SAP_ADDR_CC0, 8'h00);
    endtask
    task automatic t_stream(input logic [7:0] c0, input logic [7:0] c1, input int nb,
                            input int ns, input int dl);
        logic [23:0] m;
        run = 0;
        repeat (20) @(negedge clk);
        wr(SAP_ADDR_SPC0, c0);
        wr(SAP_ADDR_SPC1, c1);
        rise = c0[SAP_B_RISE];
        pulse = c0[SAP_B_PULSE];
        bpf = 9'(nb);
        sw = 6'(nb / ns);
        dly = 5'(dl);
        m = 24'hff_ffff << (24 - ((nb / ns - dl) < 24 ? nb / ns - dl : 24));
        for (int k = 0; k < 8; k++) begin
            @(negedge clk);
            tx_we = 1;
            tx_word = {3'(k), ~i_model.pat(k)};
            rx_got[k] = '0;
            i_model.cap[k] = '0;
        end
        @(negedge clk);
        tx_we = 0;
        run = 1;
        // four frames, 1.5 clk per bclk
        repeat (6 * nb + 40) @(negedge clk);
        for (int k = 0; k < ns; k++) begin
            chk_w(rx_got[k].data, i_model.pat(k) & m);
            chk_w(i_model.cap[k], ~i_model.pat(k) & m);
        end
    endtask
    task automatic t_master;
        logic [7:0] d;
        int         n;
        run = 0;
        wr(SAP_ADDR_SPC1, 8'h00);
        wr(SAP_ADDR_SPC0, 8'h01);
        repeat (400) @(negedge clk);
        chk_b({7'h0, bclk_oe}, 8'h01);
        @(posedge lrclk_o);
        n = 0;
        @(negedge clk);
        while (lrclk_o === 1'b1 && n < 4000) begin
            n++;
            @(negedge clk);
        end
        chk_w(24'(n), 24'h00_0500);
        wr(SAP_ADDR_CC0, 8'h01);
        wr(SAP_ADDR_SPC0, 8'h05);
        repeat (400) @(negedge clk);
        chk_b({7'h0, bclk_oe}, 8'h00);
        rd(SAP_ADDR_STAT, d);
        chk_b(d & 8'h03, 8'h02);
    endtask
    initial begin
        repeat (5) @(negedge clk);
        reset = 0;
        t_regs();
        t_stream(8'h00, 8'h00, 64, 2, 1);
        t_stream(8'h40, 8'h01, 64, 2, 0);
        t_stream(8'h40, 8'h02, 64, 2, 8);
        t_stream(8'h40, 8'h03, 64, 2, 12);
        t_stream(8'h40, 8'h04, 64, 2, 16);
        t_stream(8'h02, 8'h40, 128, 4, 1);
        t_stream(8'h04, 8'h60, 256, 8, 1);
        t_stream(8'h64, 8'h60, 256, 8, 1);
        t_master();
        stop_test();
    end
endmodule
